// File: chan_guard_pkg.sv
// constants shared by the channel supervisor and its bench
// assumes one 25 MHz clock (pclk) and an APB master on the same clock
package chan_guard_pkg;

   // ****************************************************************
   // register offsets (byte addresses, one aligned word each)
   // ****************************************************************
   localparam logic [7:0] CTRL_OFFSET   = 8'h00; // mode, curve switch, host enable
   localparam logic [7:0] CMD_OFFSET    = 8'h04; // remote current command
   localparam logic [7:0] IMAX_OFFSET   = 8'h08; // configured maximum current
   localparam logic [7:0] GAIN_OFFSET   = 8'h0C; // user characteristic gain
   localparam logic [7:0] STATUS_OFFSET = 8'h10; // read-only state view
   localparam logic [7:0] ACK_OFFSET    = 8'h14; // write-one strobes
   localparam logic [7:0] SAMPLE_OFFSET = 8'h18; // digitised analogue input

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int CTRL_MODE_BIT    = 0;  // 1 = remote host mode
   localparam int CTRL_CHAR_BIT    = 1;  // 1 = user characteristic on
   localparam int CTRL_HOSTEN_BIT  = 2;  // control-mode parameter
   localparam int CMD_DIR_BIT      = 12; // 1 = drive solenoid b
   localparam int ST_MODE_BIT      = 2;
   localparam int ST_DERATE_BIT    = 3;
   localparam int ST_ERROR_BIT     = 4;
   localparam int ST_REJECT_BIT    = 5;
   localparam int ST_TEMP_LSB      = 16;
   localparam int ACK_ERR_BIT      = 0;  // acknowledge thermal error
   localparam int ACK_REJECT_BIT   = 1;  // clear mode-reject flag

   // ****************************************************************
   // widths and reset values
   // ****************************************************************
   localparam int CUR_W    = 12;  // solenoid current in mA
   localparam int SAMPLE_W = 10;  // analogue sample resolution
   localparam int TEMP_W   = 8;   // electronics temperature in degC
   localparam int GAIN_W   = 8;   // gain, 128 = unity
   localparam logic [CUR_W-1:0]  IMAX_RESET = 12'h2BC; // 700 mA
   localparam logic [GAIN_W-1:0] GAIN_RESET = 8'h80;   // unity
   localparam int GAIN_SHIFT = 7;

   // ****************************************************************
   // thermal thresholds
   // ****************************************************************
   localparam logic [TEMP_W-1:0] DERATE_TEMP  = 8'h50; // 80 degC
   localparam logic [TEMP_W-1:0] ERROR_TEMP   = 8'h5A; // 90 degC
   localparam logic [CUR_W-1:0]  DERATE_STEP  = 12'h032; // mA cut per degC

   // ****************************************************************
   // channel states
   // ****************************************************************
   typedef enum logic [1:0] {
      ST_DISABLED,
      ST_ACTIVE,
      ST_ERROR
   } chan_state_t;

endpackage

// File: pin_sync.sv
// two-flop synchroniser for a group of pin inputs
// assumes multi-bit groups change slowly against pclk (sensor codes)
module pin_sync #(
   parameter int W = 1
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   // ****************************************************************
   // synchroniser stages
   // ****************************************************************
   logic [W-1:0] meta; // first stage, read only by q

   // both stages freeze with the clock enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= '0;
         q    <= '0;
      end else if (ce) begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule

// File: chan_guard.sv
// channel state machine, operating mode and thermal guard with APB registers
// assumes pin inputs are asynchronous and the APB master shares pclk
//
// Behaviour
// RULE_01 - derate maximum current from 80 degC upward
// RULE_02 - status bit shows derating is active
// RULE_03 - derating limit applies to both solenoids
// RULE_04 - above 90 degC enter error, outputs blocked
// RULE_05 - leave error after cooling and acknowledge
// RULE_06 - switch user characteristic on or off
// RULE_07 - each channel has own state machine
// RULE_08 - disabled channel keeps solenoid current off
// RULE_09 - mode change accepted only while disabled
// RULE_10 - active channel driven per selected mode
// RULE_11 - power-on initialises the state machine
// RULE_12 - enable via local input or host parameter
// RULE_13 - disable via local input or host parameter
// RULE_14 - two modes: local inputs or host
// RULE_15 - selected mode reported to host
// RULE_16 - analogue input taken as 10-bit sample
// RULE_17 - start disabled with outputs off
// RULE_18 - error overrides active and pending enable
// RULE_19 - derating removed below threshold automatically
module chan_guard (
   input  wire logic                             pclk,
   input  wire logic                             presetn,
   input  wire logic                             ce,
   // apb slave
   input  wire logic                             psel,
   input  wire logic                             penable,
   input  wire logic                             pwrite,
   input  wire logic [7:0]                       paddr,
   input  wire logic [31:0]                      pwdata,
   output logic      [31:0]                      prdata,
   output logic                                  pready,
   output logic                                  pslverr,
   // pins
   input  wire logic                             local_enable,
   input  wire logic                             local_dir,
   input  wire logic [chan_guard_pkg::SAMPLE_W-1:0] adc_code,
   input  wire logic [chan_guard_pkg::TEMP_W-1:0]   temp_code,
   // solenoid current setpoints
   output logic      [chan_guard_pkg::CUR_W-1:0]    sol_a,
   output logic      [chan_guard_pkg::CUR_W-1:0]    sol_b,
   output logic                                  derate_active,
   output logic                                  chan_active
);

   // ****************************************************************
   // declarations
   // ****************************************************************
   localparam int CW = chan_guard_pkg::CUR_W;
   localparam int TW = chan_guard_pkg::TEMP_W;
   localparam int SW = chan_guard_pkg::SAMPLE_W;
   localparam int GW = chan_guard_pkg::GAIN_W;

   chan_guard_pkg::chan_state_t state;      // channel state
   chan_guard_pkg::chan_state_t next_state; // combinational next state
   logic          remote_mode;   // 1 = host drives the channel
   logic          char_on;       // user characteristic enabled
   logic          host_enable;   // control-mode parameter
   logic [CW-1:0] remote_cmd;    // host current command
   logic          remote_dir;    // host direction select
   logic [CW-1:0] imax;          // configured maximum current
   logic [GW-1:0] gain;          // characteristic gain
   logic          mode_reject;   // sticky: mode write refused
   logic          rd_ready;      // read data loaded for this access
   logic          en_s;          // synchronised local enable
   logic          dir_s;         // synchronised local direction
   logic [SW-1:0] sample;        // synchronised analogue sample
   logic [TW-1:0] temp;          // synchronised temperature
   logic          wr_en;         // write completes this edge
   logic          addr_ok;       // address is mapped
   logic          want_enable;   // enable request of the current mode
   logic          over_temp;     // above error threshold
   logic [TW-1:0] over_deg;      // degrees above derate threshold
   logic [CW+TW-1:0] cut;        // current removed by derating
   logic [CW-1:0] limit;         // derated maximum
   logic [CW-1:0] base_cmd;      // command before characteristic
   logic [CW+GW-1:0] shaped;     // command after gain
   logic [CW-1:0] cmd;           // command before limit
   logic [CW-1:0] next_cur;      // limited command
   logic          drive_b;       // direction of the active mode

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   pin_sync #(.W(2)) u_sync_bits (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .d       ({local_enable, local_dir}),
      .q       ({en_s, dir_s})
   );

   // RULE_16 - 10-bit sample capture
   pin_sync #(.W(SW)) u_sync_adc (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .d       (adc_code),
      .q       (sample)
   );

   pin_sync #(.W(TW)) u_sync_temp (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .d       (temp_code),
      .q       (temp)
   );

   // ****************************************************************
   // apb decode
   // ****************************************************************
   assign wr_en  = psel && penable && pwrite && pready;
   assign pready = rd_ready && ce; // stalls while the block is frozen

   // decode of mapped word addresses
   always_comb begin
      unique case (paddr)
         chan_guard_pkg::CTRL_OFFSET,
         chan_guard_pkg::CMD_OFFSET,
         chan_guard_pkg::IMAX_OFFSET,
         chan_guard_pkg::GAIN_OFFSET,
         chan_guard_pkg::STATUS_OFFSET,
         chan_guard_pkg::ACK_OFFSET,
         chan_guard_pkg::SAMPLE_OFFSET: addr_ok = 1'b1;
         default:                       addr_ok = 1'b0;
      endcase
   end

   assign pslverr = psel && penable && pready && !addr_ok;

   // read data loaded at setup, so access cycle answers at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_ready <= 1'b0;
         prdata   <= 32'h0000_0000;
      end else if (ce) begin
         if (psel && penable && rd_ready) begin
            rd_ready <= 1'b0; // access done, release
         end else if (psel) begin
            rd_ready <= 1'b1;
            prdata   <= 32'h0000_0000;
            // RULE_15 - report mode and state
            unique case (paddr)
               chan_guard_pkg::CTRL_OFFSET: begin
                  prdata[chan_guard_pkg::CTRL_MODE_BIT]   <= remote_mode;
                  prdata[chan_guard_pkg::CTRL_CHAR_BIT]   <= char_on;
                  prdata[chan_guard_pkg::CTRL_HOSTEN_BIT] <= host_enable;
               end
               chan_guard_pkg::CMD_OFFSET: begin
                  prdata[CW-1:0]                      <= remote_cmd;
                  prdata[chan_guard_pkg::CMD_DIR_BIT] <= remote_dir;
               end
               chan_guard_pkg::IMAX_OFFSET: begin
                  prdata[CW-1:0] <= imax;
               end
               chan_guard_pkg::GAIN_OFFSET: begin
                  prdata[GW-1:0] <= gain;
               end
               chan_guard_pkg::STATUS_OFFSET: begin
                  prdata[1:0]                           <= state;
                  prdata[chan_guard_pkg::ST_MODE_BIT]   <= remote_mode;
                  prdata[chan_guard_pkg::ST_DERATE_BIT] <= derate_active;
                  prdata[chan_guard_pkg::ST_ERROR_BIT]  <= (state == chan_guard_pkg::ST_ERROR);
                  prdata[chan_guard_pkg::ST_REJECT_BIT] <= mode_reject;
                  prdata[chan_guard_pkg::ST_TEMP_LSB +: TW] <= temp;
               end
               chan_guard_pkg::SAMPLE_OFFSET: begin
                  prdata[SW-1:0] <= sample;
               end
               default: begin
                  prdata <= 32'h0000_0000; // ack and unmapped read zero
               end
            endcase
         end
      end
   end

   // ****************************************************************
   // control registers
   // ****************************************************************
   // curve switch, host enable and setpoints, writable in any state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         char_on     <= 1'b0;
         host_enable <= 1'b0;
         remote_cmd  <= '0;
         remote_dir  <= 1'b0;
         imax        <= chan_guard_pkg::IMAX_RESET;
         gain        <= chan_guard_pkg::GAIN_RESET;
      end else if (ce && wr_en) begin
         if (paddr == chan_guard_pkg::CTRL_OFFSET) begin
            // RULE_06 - characteristic on or off
            char_on     <= pwdata[chan_guard_pkg::CTRL_CHAR_BIT];
            host_enable <= pwdata[chan_guard_pkg::CTRL_HOSTEN_BIT];
         end
         if (paddr == chan_guard_pkg::CMD_OFFSET) begin
            remote_cmd <= pwdata[CW-1:0];
            remote_dir <= pwdata[chan_guard_pkg::CMD_DIR_BIT];
         end
         if (paddr == chan_guard_pkg::IMAX_OFFSET) begin
            imax <= pwdata[CW-1:0];
         end
         if (paddr == chan_guard_pkg::GAIN_OFFSET) begin
            gain <= pwdata[GW-1:0];
         end
      end
   end

   // mode bit: locked outside disabled, refusal flagged sticky
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         remote_mode <= 1'b0; // local after power-on
         mode_reject <= 1'b0;
      end else if (ce) begin
         // RULE_09 - mode locked unless disabled
         if (wr_en && paddr == chan_guard_pkg::CTRL_OFFSET &&
             pwdata[chan_guard_pkg::CTRL_MODE_BIT] != remote_mode) begin
            if (state == chan_guard_pkg::ST_DISABLED) begin
               remote_mode <= pwdata[chan_guard_pkg::CTRL_MODE_BIT];
            end else begin
               mode_reject <= 1'b1; // set wins over a same-cycle clear
            end
         end else if (wr_en && paddr == chan_guard_pkg::ACK_OFFSET &&
                      pwdata[chan_guard_pkg::ACK_REJECT_BIT]) begin
            mode_reject <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // channel state machine
   // ****************************************************************
   // RULE_14 - enable source follows the mode
   assign want_enable = remote_mode ? host_enable : en_s;
   assign over_temp   = temp > chan_guard_pkg::ERROR_TEMP;

   // next state; one instance of this logic per channel
   always_comb begin
      next_state = state;
      // RULE_07 - this channel's own machine
      unique case (state)
         chan_guard_pkg::ST_DISABLED: begin
            // RULE_12 - enable from mode's source
            if (want_enable) begin
               next_state = chan_guard_pkg::ST_ACTIVE;
            end
         end
         chan_guard_pkg::ST_ACTIVE: begin
            // RULE_13 - disable from mode's source
            if (!want_enable) begin
               next_state = chan_guard_pkg::ST_DISABLED;
            end
         end
         chan_guard_pkg::ST_ERROR: begin
            // RULE_05 - cooled and acknowledged
            if (!over_temp && wr_en && paddr == chan_guard_pkg::ACK_OFFSET &&
                pwdata[chan_guard_pkg::ACK_ERR_BIT]) begin
               next_state = chan_guard_pkg::ST_DISABLED;
            end
         end
         default: begin
            next_state = chan_guard_pkg::ST_DISABLED; // illegal code
         end
      endcase
      // RULE_04 - over-temperature forces error
      // RULE_18 - error beats any enable
      if (over_temp) begin
         next_state = chan_guard_pkg::ST_ERROR;
      end
   end

   // RULE_11 - power-on initialises machine
   // RULE_17 - start in disabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= chan_guard_pkg::ST_DISABLED;
      end else if (ce) begin
         state <= next_state;
      end
   end

   // ****************************************************************
   // derating and current command
   // ****************************************************************
   // RULE_01 - limit falls with temperature
   // RULE_19 - full limit below threshold
   assign over_deg = (temp >= chan_guard_pkg::DERATE_TEMP) ?
                     TW'(temp - chan_guard_pkg::DERATE_TEMP) : '0;
   assign cut      = over_deg * chan_guard_pkg::DERATE_STEP;
   assign limit    = (cut >= (CW+TW)'(imax)) ? '0 : CW'((CW+TW)'(imax) - cut);

   // RULE_10 - command from the selected mode
   assign base_cmd = remote_mode ? remote_cmd : {sample, 2'b00};
   assign drive_b  = remote_mode ? remote_dir : dir_s;
   assign shaped   = (base_cmd * gain) >> chan_guard_pkg::GAIN_SHIFT;
   // saturate the gained command rather than let it wrap
   assign cmd      = !char_on ? base_cmd :
                     (shaped[CW+GW-1:CW] != '0) ? {CW{1'b1}} : shaped[CW-1:0];
   assign next_cur = (cmd > limit) ? limit : cmd;

   // outputs follow next_state so a block takes effect at the same edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sol_a         <= '0;
         sol_b         <= '0;
         derate_active <= 1'b0;
         chan_active   <= 1'b0;
      end else if (ce) begin
         // RULE_02 - derating status bit
         derate_active <= (temp >= chan_guard_pkg::DERATE_TEMP);
         chan_active   <= (next_state == chan_guard_pkg::ST_ACTIVE);
         // RULE_08 - off unless active
         // RULE_03 - one limit for both
         if (next_state == chan_guard_pkg::ST_ACTIVE) begin
            sol_a <= drive_b ? '0 : next_cur;
            sol_b <= drive_b ? next_cur : '0;
         end else begin
            sol_a <= '0;
            sol_b <= '0;
         end
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence hot_s;
      ce && over_temp;
   endsequence

   sequence ack_s;
      ce && !over_temp && wr_en && paddr == chan_guard_pkg::ACK_OFFSET &&
      pwdata[chan_guard_pkg::ACK_ERR_BIT];
   endsequence

   a_disabled_off: assert property ( // RULE_08
      state != chan_guard_pkg::ST_ACTIVE |-> sol_a == '0 && sol_b == '0)
      else $error("solenoid current outside active state");

   a_error_entry: assert property ( // RULE_04
      hot_s |=> state == chan_guard_pkg::ST_ERROR && sol_a == '0 && sol_b == '0)
      else $error("over-temperature did not block channel");

   a_error_priority: assert property ( // RULE_18
      hot_s and (ce && want_enable) |=> !chan_active)
      else $error("enable won over thermal error");

   a_error_exit: assert property ( // RULE_05
      (state == chan_guard_pkg::ST_ERROR) and ack_s |=> state == chan_guard_pkg::ST_DISABLED)
      else $error("acknowledge did not clear cooled error");

   a_error_hold: assert property ( // RULE_05
      state == chan_guard_pkg::ST_ERROR && ce && !wr_en |=> state == chan_guard_pkg::ST_ERROR)
      else $error("error left without acknowledge");

   a_mode_locked: assert property ( // RULE_09
      state != chan_guard_pkg::ST_DISABLED |=> $stable(remote_mode))
      else $error("mode changed outside disabled state");

   a_enable_path: assert property ( // RULE_12
      ce && state == chan_guard_pkg::ST_DISABLED && want_enable && !over_temp
      |=> state == chan_guard_pkg::ST_ACTIVE ##0 chan_active)
      else $error("enable request not taken");

   a_disable_path: assert property ( // RULE_13
      ce && state == chan_guard_pkg::ST_ACTIVE && !want_enable && !over_temp
      |=> state == chan_guard_pkg::ST_DISABLED)
      else $error("disable request not taken");

   a_derate_limit: assert property ( // RULE_03
      ce |=> sol_a <= $past(limit) && sol_b <= $past(limit))
      else $error("solenoid above derated limit");

   a_derate_flag: assert property ( // RULE_02
      ce |=> derate_active == ($past(temp) >= chan_guard_pkg::DERATE_TEMP))
      else $error("derating flag wrong");

   a_reject_flag: assert property ( // RULE_09
      ce && wr_en && paddr == chan_guard_pkg::CTRL_OFFSET &&
      state == chan_guard_pkg::ST_ACTIVE &&
      pwdata[chan_guard_pkg::CTRL_MODE_BIT] != remote_mode |=> mode_reject)
      else $error("refused mode change not flagged");

endmodule

// File: pin_model.sv
// partner: the local pins of the amplifier (enable, direction, sensor codes)
// assumes the bench sets each request; pins move just after a rising edge
module pin_model (
   input  wire logic       pclk,
   input  wire logic       en_req,
   input  wire logic       dir_req,
   input  wire logic [9:0] adc_req,
   input  wire logic [7:0] temp_req,
   output logic            local_enable,
   output logic            local_dir,
   output logic      [9:0] adc_code,
   output logic      [7:0] temp_code
);
   timeunit 1ns;
   timeprecision 1ps;
   // defined levels from time zero, so nothing reaches the pins unknown
   initial {local_enable, local_dir, adc_code, temp_code} = '0;
   always @(posedge pclk) begin
      local_enable <= en_req;
      local_dir    <= dir_req;
      adc_code     <= adc_req;  // sensor codes change slowly, as the synchroniser needs
      temp_code    <= temp_req;
   end
endmodule

// File: tb.sv
// bench for the channel supervisor: host accesses over apb, pins via pin_model
// assumes zero-wait apb with ce high during transfers, and one 25 MHz clock
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************************************
   // signals
   // ****************************************************************
   localparam logic [7:0] A_CT = chan_guard_pkg::CTRL_OFFSET;
   localparam logic [7:0] A_CM = chan_guard_pkg::CMD_OFFSET;
   localparam logic [7:0] A_ST = chan_guard_pkg::STATUS_OFFSET;
   localparam logic [7:0] A_AK = chan_guard_pkg::ACK_OFFSET;
   logic        pclk = 1'b0, presetn = 1'b0;  // clock and reset
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;   // rd: last read word
   logic        pready, pslverr, slv, local_enable, local_dir, derate_active, chan_active;
   logic        en = 1'b0, dir = 1'b0;         // pin requests
   logic        ce = 1'b1;                     // clock enable of the block
   logic [9:0]  adc = 10'h000, adc_code;
   logic [7:0]  temp = 8'h19, temp_code;      // room temperature to start
   logic [11:0] sol_a, sol_b;
   int          errors = 0, tests_run = 0;

   always #20 pclk = ~pclk;

   chan_guard i_dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .local_enable, .local_dir, .adc_code,
      .temp_code, .sol_a, .sol_b, .derate_active, .chan_active);
   pin_model i_pins (.pclk, .en_req(en), .dir_req(dir), .adc_req(adc), .temp_req(temp),
      .local_enable, .local_dir, .adc_code, .temp_code);

   // ****************************************************************
   // tasks
   // ****************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd  = prdata;
      slv = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task automatic waitn(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // status word: f = {reject, error, derate, mode, state}
   function automatic logic [31:0] st(input logic [5:0] f);
      return {8'h00, temp, 10'h000, f};
   endfunction
   task automatic finish_test;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // watchdog: the whole run needs well under 2000 cycles
   initial begin
      #100us;
      errors++;
      finish_test;
   end

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      waitn(5);
      presetn <= 1'b1;
      waitn(3);  // let the temperature code pass the synchroniser
      rchk(A_ST, st(6'h00));
      rchk(chan_guard_pkg::IMAX_OFFSET, 32'(chan_guard_pkg::IMAX_RESET));
      rchk(chan_guard_pkg::GAIN_OFFSET, 32'(chan_guard_pkg::GAIN_RESET));
      chk(32'({chan_active, sol_a, sol_b}), 32'h0);
      apb(1'b0, 8'h1C, 32'h0);  // unmapped place
      chk(32'(slv), 32'h1);
      wr(A_CT, 32'h1);
      rchk(A_ST, st(6'h04));
      wr(A_CM, 32'h258);
      wr(A_CT, 32'h5);
      waitn(3);
      chk(32'({chan_active, sol_a, sol_b}), 32'h1258000);
      wr(A_CT, 32'h4);  // mode change while active is refused
      rchk(A_ST, st(6'h25));
      wr(A_AK, 32'h2);
      rchk(A_ST, st(6'h05));
      temp <= 8'h55;
      waitn(6);
      chk(32'({derate_active, sol_a}), 32'h11C2);
      wr(A_CM, 32'h1258);  // second solenoid
      waitn(3);
      chk(32'({sol_a, sol_b}), 32'h0001C2);
      rchk(A_ST, st(6'h0D));
      temp <= 8'h4F;
      waitn(6);
      chk(32'({derate_active, sol_b}), 32'h0258);
      temp <= 8'h5B;
      waitn(6);
      chk(32'({chan_active, sol_b}), 32'h0);
      rchk(A_ST, st(6'h1E));
      wr(A_AK, 32'h1);  // acknowledge while still too hot
      waitn(3);
      rchk(A_ST, st(6'h1E));
      temp <= 8'h5A;
      waitn(6);
      wr(A_AK, 32'h1);
      waitn(3);
      chk(32'({chan_active, sol_b}), 32'h10C8);
      temp <= 8'h19;
      wr(A_CT, 32'h1);
      waitn(3);
      chk(32'({chan_active, sol_b}), 32'h0);
      wr(A_CM, 32'h100);
      wr(chan_guard_pkg::GAIN_OFFSET, 32'hC0);
      wr(A_CT, 32'h7);
      waitn(3);
      chk(32'(sol_a), 32'h180);
      wr(A_CT, 32'h5);
      waitn(3);
      chk(32'(sol_a), 32'h100);
      wr(A_CT, 32'h1);
      waitn(2);
      wr(A_CT, 32'h0);
      rchk(A_ST, st(6'h00));
      adc <= 10'h064;
      en  <= 1'b1;
      waitn(6);
      chk(32'({chan_active, sol_a}), 32'h1190);
      rchk(chan_guard_pkg::SAMPLE_OFFSET, 32'h64);
      dir <= 1'b1;
      waitn(6);
      chk(32'({sol_a, sol_b}), 32'h000190);
      ce <= 1'b0;  // frozen block: the disable must wait for the enable
      en <= 1'b0;
      waitn(6);
      chk(32'({chan_active, sol_b}), 32'h1190);
      ce <= 1'b1;
      waitn(6);
      chk(32'({chan_active, sol_b}), 32'h0);
      finish_test;
   end
endmodule
